// *** dtr_pkg.sv ***
/*
 * dtr_pkg: shared constants for the debug/trace register front end.
 * assumes: byte-wide register port, 16-bit cpu addresses, one bus clock.
 */
package dtr_pkg;
  // ==========================================================
  // register offsets (byte addresses inside the debug block)
  localparam logic [3:0] OFF_CMP_A_HIGH  = 4'h0;
  localparam logic [3:0] OFF_CMP_A_LOW   = 4'h1;
  localparam logic [3:0] OFF_CMP_B_HIGH  = 4'h2;
  localparam logic [3:0] OFF_CMP_B_LOW   = 4'h3;
  localparam logic [3:0] OFF_TRACE_HIGH  = 4'h4;
  localparam logic [3:0] OFF_TRACE_LOW   = 4'h5;
  localparam logic [3:0] OFF_DEBUG_CTRL  = 4'h6;
  localparam logic [3:0] OFF_FORCE_RESET = 4'ha;

  // ==========================================================
  // debug_control field positions
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_ARM       = 6;
  localparam int BIT_TAG       = 5;
  localparam int BIT_BRK_EN    = 4;
  localparam int BIT_A_DIR_VAL = 3;
  localparam int BIT_A_DIR_EN  = 2;
  localparam int BIT_B_DIR_VAL = 1;
  localparam int BIT_B_DIR_EN  = 0;
  // forced_reset_request field
  localparam int BIT_FORCE_RESET = 0;

  // ==========================================================
  // reset values and sizes
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam int         TRACE_DEPTH  = 8;
  localparam int         STAGE_DEPTH  = 32;
  // staged sample: {fetch, rw, data[7:0], addr[15:0]}
  localparam int         SAMPLE_W     = 26;
endpackage : dtr_pkg

// *** dtr_debug_trace.sv ***
/*
 * dtr_debug_trace: debug comparators, trace buffer readout, control and
 * forced-reset registers, plus the staging fifo for monitored bus samples.
 * assumes: all inputs come from logic on core_clk; the register port carries
 * both cpu and serial-background accesses, told apart by acc_from_bdc.
 */
// What this block does
// (R1) cpu writes to the forced-reset register are ignored; only background writes act.
// (R2) reading the forced-reset register always returns zero.
// (R3) background write of one to bit 0 forces a full mcu reset.
// (R4) comparator bytes reset to zero, always readable, writable only while unarmed.
// (R5) each comparator matches a 16-bit value built from high and low bytes.
// (R6) trace high and low registers are read-only; writes do nothing.
// (R7) in event-only modes only low byte is stored; high reads zero.
// (R8) high-byte read keeps position; low-byte read advances to next word.
// (R9) reader fetches high byte then low byte; event bytes need only low reads.
// (R10) while armed, low-byte reads do not advance the trace buffer.
// (R11) reader should not read trace data while still armed.
// (R12) unarmed low-byte read stores last fetched opcode address in last slot.
// (R13) unarmed, buffer is an eight-deep delay line: ninth read returns first.
// (R14) debug control is readable and writable regardless of arm state.
// (R15) bit 7 enables debug; cannot be set while the mcu is secure.
// (R16) bit 6 arms; clears on run completion or written zero to it or enable.
// (R17) bit 5 picks force (0) or tag (1) break requests when breaks enabled.
// (R18) bit 4 makes triggers request breaks: end on trigger, begin on buffer full.
// (R19) bit 2 qualifies comparator a by direction: bit 3 zero write, one read.
// (R20) bit 0 qualifies comparator b by direction: bit 1 zero write, one read.
// (R21) debug registers sit in the normal map, reachable by application code.
// (R22) a run completes when full for begin trace, or on trigger for end trace.
// (R23) the forced-reset bit holds no state; it only pulses a reset request.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// staging fifo
module dtr_stage_fifo #(
  parameter int WIDTH = dtr_pkg::SAMPLE_W,
  parameter int DEPTH = dtr_pkg::STAGE_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg,  count_next;
  logic             room_reg,   room_next;
  logic             push;
  logic             pop;

  always_comb begin
    push        = in_valid && room_reg;
    pop         = out_ready && (count_reg != '0);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    // ready is kept in a flop so the upstream port sees no logic
    room_next = (count_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      room_reg   <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
      room_reg   <= room_next;
    end
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  assign in_ready  = room_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
endmodule : dtr_stage_fifo

// ============================================================
// top
module dtr_debug_trace #(
  parameter int TRACE_DEPTH = dtr_pkg::TRACE_DEPTH,
  parameter int STAGE_DEPTH = dtr_pkg::STAGE_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // register port
  input  wire logic        acc_rd,
  input  wire logic        acc_wr,
  input  wire logic        acc_from_bdc,
  input  wire logic [3:0]  acc_addr,
  input  wire logic [7:0]  acc_wdata,
  output logic      [7:0]  acc_rdata,
  output logic             acc_rvalid,
  // monitored cpu bus samples
  input  wire logic        mon_valid,
  output logic             mon_ready,
  input  wire logic [15:0] mon_addr,
  input  wire logic [7:0]  mon_data,
  input  wire logic        mon_rw,
  input  wire logic        mon_fetch,
  // mode inputs
  input  wire logic        mcu_secure,
  input  wire logic        trace_begin_mode,
  input  wire logic        event_only_mode,
  // outputs
  output logic             force_reset_pulse,
  output logic             break_req,
  output logic             break_tag,
  output logic             run_active_flag
);
  localparam int CW = $clog2(TRACE_DEPTH + 1);

  // ==========================================================
  // staging fifo between bus monitor and trace capture
  logic                         stg_valid;
  logic                         stg_ready;
  logic [dtr_pkg::SAMPLE_W-1:0] stg_data;
  logic                         stg_in_ready;

  dtr_stage_fifo #(
    .WIDTH (dtr_pkg::SAMPLE_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (mon_valid),
    .in_ready  (stg_in_ready),
    .in_data   ({mon_fetch, mon_rw, mon_data, mon_addr}),
    .out_valid (stg_valid),
    .out_ready (stg_ready),
    .out_data  (stg_data)
  );
  assign mon_ready = stg_in_ready;

  // ==========================================================
  // state
  logic [7:0]  cmp_a_high_reg, cmp_a_high_next;
  logic [7:0]  cmp_a_low_reg,  cmp_a_low_next;
  logic [7:0]  cmp_b_high_reg, cmp_b_high_next;
  logic [7:0]  cmp_b_low_reg,  cmp_b_low_next;
  logic [7:0]  ctrl_reg,       ctrl_next;
  logic [15:0] trace_reg [TRACE_DEPTH];
  logic [15:0] trace_next [TRACE_DEPTH];
  logic [CW-1:0] stored_reg,   stored_next;
  logic        capturing_reg,  capturing_next;
  logic [15:0] last_fetch_reg, last_fetch_next;
  logic [7:0]  rdata_reg,      rdata_next;
  logic        rvalid_reg,     rvalid_next;
  logic        force_reg,      force_next;
  logic        brk_reg,        brk_next;
  logic        tag_reg,        tag_next;

  // sample fields
  logic [15:0] s_addr;
  logic [7:0]  s_data;
  logic        s_rw;
  logic        s_take;
  logic        match_a;
  logic        match_b;
  logic        trigger;
  logic        do_store;
  logic [15:0] store_word;
  logic        run_done;
  logic        low_read;
  logic        cpu_wr;
  logic        new_en;

  function automatic logic cmp_hit(input logic [15:0] addr, input logic [7:0] hi,
                                   input logic [7:0] lo, input logic rw,
                                   input logic dir_en, input logic dir_val);
    cmp_hit = (addr == {hi, lo}) && (!dir_en || (rw == dir_val));
  endfunction : cmp_hit

  // the capture side stalls the fifo while a trace-low read shifts the
  // buffer, so both never move it in one cycle
  assign low_read  = acc_rd && (acc_addr == dtr_pkg::OFF_TRACE_LOW);
  assign stg_ready = !low_read;

  // ==========================================================
  // next-state
  always_comb begin
    cmp_a_high_next = cmp_a_high_reg;
    cmp_a_low_next  = cmp_a_low_reg;
    cmp_b_high_next = cmp_b_high_reg;
    cmp_b_low_next  = cmp_b_low_reg;
    ctrl_next       = ctrl_reg;
    trace_next      = trace_reg;
    stored_next     = stored_reg;
    capturing_next  = capturing_reg;
    last_fetch_next = last_fetch_reg;
    rdata_next      = rdata_reg;
    rvalid_next     = acc_rd;
    force_next      = 1'b0;
    brk_next        = 1'b0;
    tag_next        = tag_reg;

    s_addr  = stg_data[15:0];
    s_data  = stg_data[23:16];
    s_rw    = stg_data[24];
    s_take  = stg_valid && stg_ready;
    // 16-bit compare value from the two byte registers, see (R5)
    match_a = cmp_hit(s_addr, cmp_a_high_reg, cmp_a_low_reg, s_rw,
                      ctrl_reg[dtr_pkg::BIT_A_DIR_EN],
                      ctrl_reg[dtr_pkg::BIT_A_DIR_VAL]); // see (R19)
    match_b = cmp_hit(s_addr, cmp_b_high_reg, cmp_b_low_reg, s_rw,
                      ctrl_reg[dtr_pkg::BIT_B_DIR_EN],
                      ctrl_reg[dtr_pkg::BIT_B_DIR_VAL]); // see (R20)
    trigger = ctrl_reg[dtr_pkg::BIT_ARM] && s_take &&
              (event_only_mode ? match_b : (match_a || match_b));

    if (s_take && stg_data[25]) begin
      last_fetch_next = s_addr;
    end

    // event-only stores the data byte with a zero high half, see (R7)
    store_word = event_only_mode ? {dtr_pkg::ZERO_BYTE, s_data} : s_addr;
    do_store   = 1'b0;
    run_done   = 1'b0;
    if (ctrl_reg[dtr_pkg::BIT_ARM]) begin
      if (trace_begin_mode || event_only_mode) begin
        // begin trace: trigger opens capture, a full buffer ends the run
        if (trigger) begin
          capturing_next = 1'b1;
        end
        do_store = s_take && (capturing_reg || trigger) &&
                   (!event_only_mode || match_b);
        if (do_store && (stored_reg == CW'(TRACE_DEPTH - 1))) begin
          run_done = 1'b1; // see (R22)
        end
      end else begin
        // end trace: circular capture until the trigger
        do_store = s_take;
        run_done = trigger; // see (R22)
      end
    end

    if (do_store) begin
      for (int i = 0; i < TRACE_DEPTH - 1; i++) begin
        trace_next[i] = trace_reg[i+1];
      end
      trace_next[TRACE_DEPTH-1] = store_word;
      if (stored_reg != CW'(TRACE_DEPTH)) begin
        stored_next = stored_reg + 1'b1;
      end
    end

    if (run_done) begin
      ctrl_next[dtr_pkg::BIT_ARM] = 1'b0; // see (R16)
      capturing_next = 1'b0;
      brk_next = ctrl_reg[dtr_pkg::BIT_BRK_EN]; // see (R18)
      tag_next = ctrl_reg[dtr_pkg::BIT_TAG]; // see (R17)
    end

    // low read shifts only when unarmed, refilling the tail, see (R8)
    if (low_read && !ctrl_reg[dtr_pkg::BIT_ARM]) begin // see (R10)
      for (int i = 0; i < TRACE_DEPTH - 1; i++) begin
        trace_next[i] = trace_reg[i+1]; // see (R13)
      end
      trace_next[TRACE_DEPTH-1] = last_fetch_reg; // see (R12)
    end

    // register writes
    cpu_wr = acc_wr && !acc_from_bdc;
    new_en = acc_wdata[dtr_pkg::BIT_ENABLE] && !mcu_secure; // see (R15)
    if (acc_wr) begin
      if (acc_addr == dtr_pkg::OFF_FORCE_RESET) begin
        // pulse only, nothing stored, see (R23)
        force_next = acc_from_bdc && acc_wdata[dtr_pkg::BIT_FORCE_RESET]; // see (R1) (R3)
      end else if (ctrl_reg[dtr_pkg::BIT_ARM]) begin
        if (acc_addr == dtr_pkg::OFF_DEBUG_CTRL) begin
          ctrl_next = {new_en, acc_wdata[6] && new_en, acc_wdata[5:0]}; // see (R14)
        end
      end else if (acc_addr == dtr_pkg::OFF_CMP_A_HIGH) begin
        cmp_a_high_next = acc_wdata; // see (R4)
      end else if (acc_addr == dtr_pkg::OFF_CMP_A_LOW) begin
        cmp_a_low_next = acc_wdata; // see (R4)
      end else if (acc_addr == dtr_pkg::OFF_CMP_B_HIGH) begin
        cmp_b_high_next = acc_wdata; // see (R4)
      end else if (acc_addr == dtr_pkg::OFF_CMP_B_LOW) begin
        cmp_b_low_next = acc_wdata; // see (R4)
      end else if (acc_addr == dtr_pkg::OFF_DEBUG_CTRL) begin
        // arm survives only with enable; writing 0 to either ends the run
        ctrl_next = {new_en, acc_wdata[6] && new_en, acc_wdata[5:0]}; // see (R14) (R16)
      end
      // trace registers take no writes, see (R6)
      if ((acc_addr == dtr_pkg::OFF_DEBUG_CTRL) && new_en &&
          acc_wdata[dtr_pkg::BIT_ARM]) begin
        // arming wins over a run ending in the same cycle; starts fresh run
        stored_next    = '0;
        capturing_next = 1'b0;
      end
    end
    if (cpu_wr && !new_en && (acc_addr == dtr_pkg::OFF_DEBUG_CTRL)) begin
      capturing_next = 1'b0;
    end

    // reads: registers sit in the normal map, see (R21)
    if (acc_rd) begin
      if (acc_addr == dtr_pkg::OFF_CMP_A_HIGH) begin
        rdata_next = cmp_a_high_reg;
      end else if (acc_addr == dtr_pkg::OFF_CMP_A_LOW) begin
        rdata_next = cmp_a_low_reg;
      end else if (acc_addr == dtr_pkg::OFF_CMP_B_HIGH) begin
        rdata_next = cmp_b_high_reg;
      end else if (acc_addr == dtr_pkg::OFF_CMP_B_LOW) begin
        rdata_next = cmp_b_low_reg;
      end else if (acc_addr == dtr_pkg::OFF_TRACE_HIGH) begin
        rdata_next = event_only_mode ? dtr_pkg::ZERO_BYTE
                                     : trace_reg[0][15:8]; // see (R7) (R8)
      end else if (acc_addr == dtr_pkg::OFF_TRACE_LOW) begin
        rdata_next = trace_reg[0][7:0];
      end else if (acc_addr == dtr_pkg::OFF_DEBUG_CTRL) begin
        rdata_next = ctrl_reg; // see (R14)
      end else begin
        rdata_next = dtr_pkg::ZERO_BYTE; // forced reset reads zero, see (R2)
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cmp_a_high_reg <= dtr_pkg::RST_BYTE; // see (R4)
      cmp_a_low_reg  <= dtr_pkg::RST_BYTE;
      cmp_b_high_reg <= dtr_pkg::RST_BYTE;
      cmp_b_low_reg  <= dtr_pkg::RST_BYTE;
      ctrl_reg       <= dtr_pkg::RST_BYTE;
      for (int i = 0; i < TRACE_DEPTH; i++) begin
        trace_reg[i] <= 16'h0000;
      end
      stored_reg     <= '0;
      capturing_reg  <= 1'b0;
      last_fetch_reg <= 16'h0000;
      rdata_reg      <= dtr_pkg::RST_BYTE;
      rvalid_reg     <= 1'b0;
      force_reg      <= 1'b0;
      brk_reg        <= 1'b0;
      tag_reg        <= 1'b0;
    end else begin
      cmp_a_high_reg <= cmp_a_high_next;
      cmp_a_low_reg  <= cmp_a_low_next;
      cmp_b_high_reg <= cmp_b_high_next;
      cmp_b_low_reg  <= cmp_b_low_next;
      ctrl_reg       <= ctrl_next;
      trace_reg      <= trace_next;
      stored_reg     <= stored_next;
      capturing_reg  <= capturing_next;
      last_fetch_reg <= last_fetch_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      force_reg      <= force_next;
      brk_reg        <= brk_next;
      tag_reg        <= tag_next;
    end
  end

  assign acc_rdata         = rdata_reg;
  assign acc_rvalid        = rvalid_reg;
  assign force_reset_pulse = force_reg;
  assign break_req         = brk_reg;
  assign break_tag         = tag_reg;
  assign run_active_flag   = ctrl_reg[dtr_pkg::BIT_ARM];
endmodule : dtr_debug_trace
`default_nettype wire

// *** dtr_props.sv ***
/* dtr_props: port-level timing checks for the debug trace block.
   assumes: bound onto dtr_debug_trace, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// checker
module dtr_props (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       acc_rd,
  input wire logic       acc_wr,
  input wire logic       acc_from_bdc,
  input wire logic [3:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic       acc_rvalid,
  input wire logic       mcu_secure,
  input wire logic       event_only_mode,
  input wire logic       force_reset_pulse,
  input wire logic       break_req,
  input wire logic       break_tag,
  input wire logic       run_active_flag
);
  logic      tag_reg;
  wire logic frq = acc_wr && acc_from_bdc && acc_addr == 4'ha && acc_wdata[0];
  wire logic cw  = acc_wr && acc_addr == 4'h6;
  // shadow of the tag bit, so the break type can be judged without the body
  always_ff @(posedge core_clk) begin
    if (!resetn) tag_reg <= 1'b0;
    else if (cw) tag_reg <= acc_wdata[5];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  rd_answer_a: assert property (acc_rvalid == $past(acc_rd))
    else $error("read answer out of step");
  force_bdc_a: assert property (force_reset_pulse |-> $past(frq))
    else $error("reset request without background write");
  force_fire_a: assert property (frq |=> force_reset_pulse)
    else $error("background reset write gave no request");
  force_once_a: assert property (force_reset_pulse |=> !force_reset_pulse)
    else $error("reset request longer than one cycle");
  force_zero_a: assert property (acc_rd && acc_addr == 4'ha |=> acc_rdata == 8'h00)
    else $error("forced reset register read not zero");
  secure_arm_a: assert property (cw && mcu_secure |=> !run_active_flag)
    else $error("armed while secure");
  arm_set_a: assert property (cw && acc_wdata[7:6] == 2'b11 && !mcu_secure
    |=> run_active_flag) else $error("arm write did not arm");
  arm_clear_a: assert property (cw && !(acc_wdata[7] && acc_wdata[6])
    |=> !run_active_flag) else $error("disarm write did not clear");
  break_end_a: assert property (break_req |-> $past(run_active_flag)
    && (!run_active_flag || $past(cw))) else $error("break outside run completion");
  break_tag_a: assert property (break_req |-> break_tag == tag_reg)
    else $error("break type differs from tag bit");
  event_hi_a: assert property (event_only_mode && acc_rd && acc_addr == 4'h4
    |=> acc_rdata == 8'h00) else $error("event mode high byte not zero");
endmodule : dtr_props
`default_nettype wire

// *** dtr_bus_host.sv ***
/* dtr_bus_host: monitored cpu bus source with valid/ready handshake.
   assumes: req pulses one sample, or held high streams samples. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bus sample source
module dtr_bus_host (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        req,
  input  wire logic [15:0] s_addr,
  input  wire logic [7:0]  s_data,
  input  wire logic        s_rw,
  input  wire logic        s_fetch,
  input  wire logic        mon_ready,
  output logic             mon_valid,
  output logic      [15:0] mon_addr,
  output logic      [7:0]  mon_data,
  output logic             mon_rw,
  output logic             mon_fetch,
  output logic      [15:0] taken_cnt
);
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mon_valid <= 1'b0;
      mon_addr  <= 16'h0000;
      mon_data  <= 8'h00;
      mon_rw    <= 1'b0;
      mon_fetch <= 1'b0;
      taken_cnt <= 16'h0000;
    end else begin
      if (mon_valid && mon_ready) taken_cnt <= taken_cnt + 16'h0001;
      if (req && (!mon_valid || mon_ready)) begin
        mon_valid <= 1'b1;
        mon_addr  <= s_addr;
        mon_data  <= s_data;
        mon_rw    <= s_rw;
        mon_fetch <= s_fetch;
      end else if (mon_ready) begin
        // idle address and data lines toggle while ready is high, so a stale value is never mistaken for data
        mon_valid <= 1'b0;
        mon_addr  <= ~mon_addr;
        mon_data  <= ~mon_data;
      end
    end
  end
endmodule : dtr_bus_host
`default_nettype wire

// *** dtr_testbench.sv ***
/* testbench: directed scenarios for the debug trace register block.
   assumes: dtr_debug_trace, dtr_bus_host and dtr_props compiled first. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench
module testbench;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        acc_rd = 1'b0;
  logic        acc_wr = 1'b0;
  logic        acc_from_bdc = 1'b0;
  logic [3:0]  acc_addr = 4'h0;
  logic [7:0]  acc_wdata = 8'h00;
  logic        mcu_secure = 1'b0;
  logic        trace_begin_mode = 1'b0;
  logic        event_only_mode = 1'b0;
  logic        req = 1'b0;
  logic        s_rw = 1'b0;
  logic        s_fetch = 1'b0;
  logic [15:0] s_addr = 16'h0000;
  logic [7:0]  s_data = 8'h00;
  logic [7:0]  acc_rdata, mon_data;
  logic [15:0] mon_addr, taken_cnt;
  logic        acc_rvalid, mon_valid, mon_ready, mon_rw, mon_fetch;
  logic        force_reset_pulse, break_req, break_tag, run_active_flag;
  int          fails = 0;
  int          comparisons = 0;
  always #10 core_clk = ~core_clk;
  dtr_debug_trace dut_u (.core_clk, .resetn, .acc_rd, .acc_wr, .acc_from_bdc, .acc_addr,
    .acc_wdata, .acc_rdata, .acc_rvalid, .mon_valid, .mon_ready, .mon_addr, .mon_data,
    .mon_rw, .mon_fetch, .mcu_secure, .trace_begin_mode, .event_only_mode,
    .force_reset_pulse, .break_req, .break_tag, .run_active_flag);
  dtr_bus_host host_u (.core_clk, .resetn, .req, .s_addr, .s_data, .s_rw, .s_fetch,
    .mon_ready, .mon_valid, .mon_addr, .mon_data, .mon_rw, .mon_fetch, .taken_cnt);
  task automatic end_sim();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkb
  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
  endtask : do_reset
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic bdc);
    @(posedge core_clk);
    acc_wr       <= 1'b1;
    acc_addr     <= a;
    acc_wdata    <= d;
    acc_from_bdc <= bdc;
    @(posedge core_clk);
    acc_wr       <= 1'b0;
    acc_from_bdc <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    acc_rd   <= 1'b1;
    acc_addr <= a;
    @(posedge core_clk);
    acc_rd <= 1'b0;
    #1;
    d = acc_rdata;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
    chkb(acc_rvalid, 1'b1);
  endtask : rdc
  task automatic send(input logic [15:0] a, input logic [7:0] d, input logic rw,
                      input logic f);
    int n = 0;
    @(posedge core_clk);
    req     <= 1'b1;
    s_addr  <= a;
    s_data  <= d;
    s_rw    <= rw;
    s_fetch <= f;
    @(posedge core_clk);
    req <= 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (mon_valid === 1'b1 && n < 50);
    if (mon_valid !== 1'b0) begin
      fails++;
      end_sim();
    end
  endtask : send
  task automatic wait_brk();
    int n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (break_req !== 1'b1 && n < 40);
    chkb(break_req, 1'b1);
    if (break_req !== 1'b1) end_sim();
  endtask : wait_brk
  task automatic t_resets();
    for (int i = 0; i < 4; i++) rdc(4'(i), 8'h00);
    rdc(4'ha, 8'h00);
    rdc(4'h7, 8'h00);
  endtask : t_resets
  task automatic t_force();
    wr(4'h6, 8'h80, 1'b0);
    wr(4'ha, 8'h01, 1'b0);
    chkb(force_reset_pulse, 1'b0);
    wr(4'ha, 8'h01, 1'b1);
    chkb(force_reset_pulse, 1'b1);
    rdc(4'ha, 8'h00);
    do_reset();
    rdc(4'h6, 8'h00);
  endtask : t_force
  task automatic t_regs();
    logic [7:0] v [4] = '{8'h12, 8'h34, 8'hbe, 8'hef};
    for (int i = 0; i < 4; i++) wr(4'(i), v[i], 1'b0);
    for (int i = 0; i < 4; i++) rdc(4'(i), v[i]);
    wr(4'h6, 8'h2f, 1'b0);
    rdc(4'h6, 8'h2f);
  endtask : t_regs
  task automatic t_secure();
    @(posedge core_clk);
    mcu_secure <= 1'b1;
    wr(4'h6, 8'hc0, 1'b0);
    rdc(4'h6, 8'h00);
    @(posedge core_clk);
    mcu_secure <= 1'b0;
    wr(4'h6, 8'h80, 1'b0);
    rdc(4'h6, 8'h80);
  endtask : t_secure
  task automatic t_profile();
    logic [7:0] d;
    // eight priming reads, the ninth shows the first captured fetch
    for (int i = 0; i < 9; i++) begin
      send(16'h44a0 + 16'(i), 8'h00, 1'b1, 1'b1);
      repeat (3) @(posedge core_clk);
      rd(4'h4, d);
      if (i < 8) rd(4'h5, d);
    end
    chk(d, 8'h44);
    rdc(4'h5, 8'ha0);
  endtask : t_profile
  task automatic t_armed();
    wr(4'h6, 8'hc0, 1'b0);
    chkb(run_active_flag, 1'b1);
    wr(4'h1, 8'h55, 1'b0);
    rdc(4'h1, 8'h34);
    wr(4'h4, 8'hff, 1'b0);
    rdc(4'h4, 8'h44);
    rdc(4'h5, 8'ha1);
    rdc(4'h5, 8'ha1);
    wr(4'h6, 8'h40, 1'b0);
    chkb(run_active_flag, 1'b0);
  endtask : t_armed
  task automatic dir_run(input logic [7:0] c, input logic [15:0] a, input logic ok_rw,
                         input logic tag);
    wr(4'h6, c, 1'b0);
    send(a, 8'h00, ~ok_rw, 1'b0);
    repeat (8) @(posedge core_clk);
    #1;
    chkb(run_active_flag, 1'b1);
    send(a, 8'h00, ok_rw, 1'b0);
    wait_brk();
    chkb(run_active_flag, 1'b0);
    chkb(break_tag, tag);
  endtask : dir_run
  task automatic t_dir();
    dir_run(8'hfc, 16'h1234, 1'b1, 1'b1);
    dir_run(8'hd1, 16'hbeef, 1'b0, 1'b0);
  endtask : t_dir
  task automatic t_event();
    @(posedge core_clk);
    event_only_mode <= 1'b1;
    wr(4'h2, 8'h20, 1'b0);
    wr(4'h3, 8'h00, 1'b0);
    wr(4'h6, 8'hd0, 1'b0);
    for (int i = 0; i < 8; i++) send(16'h2000, 8'hc0 + 8'(i), 1'b0, 1'b0);
    wait_brk();
    chkb(run_active_flag, 1'b0);
    rdc(4'h4, 8'h00);
    for (int i = 0; i < 8; i++) rdc(4'h5, 8'hc0 + 8'(i));
    @(posedge core_clk);
    event_only_mode <= 1'b0;
  endtask : t_event
  task automatic t_begin();
    @(posedge core_clk);
    trace_begin_mode <= 1'b1;
    wr(4'h6, 8'hd0, 1'b0);
    send(16'h0300, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) send(16'h1234 + 16'(i), 8'h00, 1'b0, 1'b0);
    wait_brk();
    for (int i = 0; i < 8; i++) begin
      rdc(4'h4, 8'h12);
      rdc(4'h5, 8'h34 + 8'(i));
    end
    @(posedge core_clk);
    trace_begin_mode <= 1'b0;
  endtask : t_begin
  task automatic t_fill();
    logic [15:0] c0;
    int          n = 0;
    wr(4'h6, 8'h00, 1'b0);
    c0 = taken_cnt;
    // held low-byte reads stall the drain, so the staging fifo fills up
    @(posedge core_clk);
    acc_rd   <= 1'b1;
    acc_addr <= 4'h5;
    req      <= 1'b1;
    s_addr   <= 16'h0100;
    repeat (60) @(posedge core_clk);
    #1;
    chkb(mon_ready, 1'b0);
    chk(8'(taken_cnt - c0), 8'h20);
    @(posedge core_clk);
    acc_rd <= 1'b0;
    req    <= 1'b0;
    while (mon_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chkb(mon_ready, 1'b1);
    if (mon_ready !== 1'b1) end_sim();
  endtask : t_fill
  initial begin
    do_reset();
    t_resets();
    t_force();
    t_regs();
    t_secure();
    t_profile();
    t_armed();
    t_dir();
    t_event();
    t_begin();
    t_fill();
    end_sim();
  end
endmodule : testbench
bind dtr_debug_trace dtr_props props_u (.core_clk, .resetn, .acc_rd, .acc_wr,
  .acc_from_bdc, .acc_addr, .acc_wdata, .acc_rdata, .acc_rvalid, .mcu_secure,
  .event_only_mode, .force_reset_pulse, .break_req, .break_tag, .run_active_flag);
`default_nettype wire
